// ===== rtl/mpa_core.sv
// transmit pacing, pause timers and station address table of the MAC
// assumes frame engine events are single-cycle pulses on REF_CLK
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps

module mpa_core
  import mpa_pkg::*;
#(
  parameter int SLOT_CYC_10 = SLOT_BITS * BIT_PS_10 / CLK_PERIOD_PS,
  parameter int ENTRIES = 8
) (
  // clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // link speed
  input wire logic [1:0] LINK_SPEED,
  // frame engine transmit events
  input wire logic TX_DONE,
  input wire logic TX_COLL_DEFER,
  input wire logic TX_PAUSE_SENT,
  input wire logic [15:0] TX_PAUSE_TIME,
  input wire logic RX_FLOW_HOLD,
  // frame engine receive events
  input wire logic RX_PAUSE_RCVD,
  input wire logic [15:0] RX_PAUSE_TIME,
  input wire logic RX_DA_VALID,
  input wire logic [47:0] RX_DA,
  // to the frame engine
  output logic TX_START_OK,
  output logic TX_PAUSE_REQ,
  output logic PACING_ACTIVE,
  output logic ADDR_MATCH,
  output logic ADDR_MATCH_VALID,
  // wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic ACK_O,
  output logic [31:0] DAT_O
);

  // ===========================================
  // state
  typedef struct packed {
    logic [PACE_W-1:0] pace;
    logic [TMR_W-1:0] rxp;
    logic [TMR_W-1:0] txp;
    logic [SLOT_W-1:0] slot;
    logic [GAP_W-1:0] gap;
    mpa_gate_e gate;
    logic [IDX_W-1:0] idx;
    logic [ENTRIES-1:0][7:0] b0;
    logic [7:0] b1;
    logic [31:0] hi;
    logic ack;
    logic [31:0] dat;
    logic start_ok;
    logic pause_req;
    logic match;
    logic match_valid;
    logic pace_act;
  } mpa_state_s;

  mpa_state_s st_r;
  mpa_state_s st_nxt;

  // ===========================================
  // helpers
  function automatic logic [TMR_W-1:0] dec_sat(
    input logic [TMR_W-1:0] v
  );
    dec_sat = (v == '0) ? v : v - 16'h0001;
  endfunction

  function automatic logic [SLOT_W-1:0] slot_len(
    input logic [1:0] spd
  );
    case (spd)
      SPD_10: slot_len = SLOT_W'(SLOT_CYC_10 - 1);
      SPD_100: slot_len = SLOT_W'(SLOT_CYC_100 - 1);
      default: slot_len = SLOT_W'(SLOT_CYC_1000 - 1);
    endcase
  endfunction

  function automatic logic [GAP_W-1:0] gap_len(
    input logic [1:0] spd,
    input logic stretch
  );
    logic [GAP_W-1:0] g;
    case (spd)
      SPD_10: g = GAP_W'(IPG_CYC_10);
      SPD_100: g = GAP_W'(IPG_CYC_100);
      default: g = GAP_W'(IPG_CYC_1000);
    endcase
    gap_len = stretch ? GAP_W'(g * PACE_GAPS) : g;
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] sel
  );
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = m;
  endfunction

  // ===========================================
  // next state
  logic slot_tick;
  logic req;
  logic [31:0] lo_view;
  logic [31:0] wlo;
  logic [31:0] whi;
  logic [31:0] rd;
  logic [4:0] pace_dec;

  always_comb begin
    st_nxt = st_r;
    slot_tick = (st_r.slot == '0);
    req = CYC_I && STB_I;
    lo_view = '0;
    lo_view[LO_B0_POS +: 8] = st_r.b0[st_r.idx];
    lo_view[LO_B1_POS +: 8] = st_r.b1;
    wlo = merge(lo_view, DAT_I, SEL_I);
    whi = merge(st_r.hi, DAT_I, SEL_I);
    pace_dec = (st_r.pace == '0) ? st_r.pace : st_r.pace - 5'h01;
    st_nxt.pause_req = 1'b0;
    st_nxt.match_valid = 1'b0;

    // slot tick generator
    st_nxt.slot = slot_tick ? slot_len(LINK_SPEED) : st_r.slot - 1'b1;

    // pacing count and gap after each frame
    if (TX_DONE) begin
      if (TX_COLL_DEFER) begin
        st_nxt.pace = PACE_LOAD;
        st_nxt.gap = gap_len(LINK_SPEED, 1'b0);
      end else begin
        st_nxt.pace = pace_dec;
        st_nxt.gap = gap_len(LINK_SPEED, st_r.pace != '0);
      end
      st_nxt.gate = GATE_GAP;
    end else begin
      case (st_r.gate)
        GATE_GAP: begin
          if (st_r.gap <= 12'h001) begin
            st_nxt.gate = GATE_OPEN;
            st_nxt.gap = '0;
          end else begin
            st_nxt.gap = st_r.gap - 12'h001;
          end
        end
        default: begin
          st_nxt.gap = '0;
        end
      endcase
    end

    // receive-side pause timer
    if (TX_PAUSE_SENT && TX_PAUSE_TIME == PAUSE_MAX) begin
      st_nxt.rxp = RXP_LOAD;
    end else if (slot_tick && st_r.rxp != '0) begin
      st_nxt.rxp = dec_sat(st_r.rxp);
      if (st_r.rxp == 16'h0001 && RX_FLOW_HOLD) begin
        st_nxt.pause_req = 1'b1;
        st_nxt.rxp = RXP_LOAD;
      end
    end

    // transmit-side pause timer
    if (RX_PAUSE_RCVD) begin
      st_nxt.txp = RX_PAUSE_TIME;
    end else if (slot_tick) begin
      st_nxt.txp = dec_sat(st_r.txp);
    end

    // transmit start gate
    st_nxt.start_ok = (st_nxt.txp == '0) && !TX_DONE &&
      (st_nxt.gate == GATE_OPEN);

    // pacing flag registered with the count it reflects
    st_nxt.pace_act = (st_nxt.pace != '0);

    // destination address match
    if (RX_DA_VALID) begin
      st_nxt.match_valid = 1'b1;
      st_nxt.match = 1'b0;
      for (int e = 0; e < ENTRIES; e++) begin
        if (RX_DA == {st_r.hi[7:0], st_r.hi[15:8], st_r.hi[23:16],
                      st_r.hi[31:24], st_r.b1, st_r.b0[e]}) begin
          st_nxt.match = 1'b1;
        end
      end
    end

    // bus read mux
    case (ADR_I)
      OFS_PACE: rd = {27'h0, st_r.pace};
      OFS_RX_PAUSE_TIMER_VIEW: rd = {16'h0, st_r.rxp};
      OFS_TX_PAUSE_TIMER_VIEW: rd = {16'h0, st_r.txp};
      OFS_ADDR_LO: rd = lo_view;
      OFS_ADDR_HI: rd = st_r.hi;
      OFS_INDEX: rd = {29'h0, st_r.idx};
      default: rd = 32'h0000_0000;
    endcase

    // bus handshake: ack one cycle after request, write at ack edge
    st_nxt.ack = req && !st_r.ack;
    if (req && !st_r.ack) begin
      st_nxt.dat = rd;
    end
    if (req && st_r.ack && WE_I) begin
      case (ADR_I)
        OFS_ADDR_LO: begin
          st_nxt.b0[st_r.idx] = wlo[LO_B0_POS +: 8];
          st_nxt.b1 = wlo[LO_B1_POS +: 8];
        end
        OFS_ADDR_HI: begin
          st_nxt.hi = whi;
          st_nxt.hi[HI_GROUP_POS] = 1'b0;
        end
        OFS_INDEX: begin
          if (SEL_I[0]) begin
            st_nxt.idx = DAT_I[IDX_W-1:0];
          end
        end
        default: begin
          st_nxt.idx = st_r.idx;
        end
      endcase
    end
  end

  // ===========================================
  // registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_r.pace <= PACE_RST;
      st_r.rxp <= TMR_RST;
      st_r.txp <= TMR_RST;
      st_r.slot <= '0;
      st_r.gap <= '0;
      st_r.gate <= GATE_OPEN;
      st_r.idx <= '0;
      st_r.b0 <= '0;
      st_r.b1 <= BYTE_RST;
      st_r.hi <= ADDR_HI_RST;
      st_r.ack <= 1'b0;
      st_r.dat <= 32'h0000_0000;
      st_r.start_ok <= 1'b0;
      st_r.pause_req <= 1'b0;
      st_r.match <= 1'b0;
      st_r.match_valid <= 1'b0;
      st_r.pace_act <= 1'b0;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  // ===========================================
  // outputs
  assign TX_START_OK = st_r.start_ok;
  assign TX_PAUSE_REQ = st_r.pause_req;
  assign PACING_ACTIVE = st_r.pace_act;
  assign ADDR_MATCH = st_r.match;
  assign ADDR_MATCH_VALID = st_r.match_valid;
  assign ACK_O = st_r.ack;
  assign DAT_O = st_r.dat;

endmodule // mpa_core

// ===== rtl/mpa_pkg.sv
// constants for the pacing, pause timer and station address block
// assumes a 100 MHz MAC clock and a 32-bit classic Wishbone slave port
package mpa_pkg;

  // ===========================================
  // register byte offsets
  localparam logic [7:0] OFS_PACE = 8'h00;
  localparam logic [7:0] OFS_RX_PAUSE_TIMER_VIEW = 8'h04;
  localparam logic [7:0] OFS_TX_PAUSE_TIMER_VIEW = 8'h08;
  localparam logic [7:0] OFS_ADDR_LO = 8'h0c;
  localparam logic [7:0] OFS_ADDR_HI = 8'h10;
  localparam logic [7:0] OFS_INDEX = 8'h14;

  // ===========================================
  // field positions and reset values
  localparam int PACE_W = 5;
  localparam int TMR_W = 16;
  localparam int IDX_W = 3;
  localparam int LO_B0_POS = 8;
  localparam int LO_B1_POS = 0;
  localparam int HI_GROUP_POS = 0;
  localparam logic [4:0] PACE_RST = 5'h00;
  localparam logic [4:0] PACE_LOAD = 5'h1f;
  localparam logic [15:0] TMR_RST = 16'h0000;
  localparam logic [15:0] RXP_LOAD = 16'hff00;
  localparam logic [15:0] PAUSE_MAX = 16'hffff;
  localparam logic [31:0] ADDR_HI_RST = 32'h0000_0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ===========================================
  // link speed codes
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;

  // ===========================================
  // timing: slot is 512 bit times, gap is 96 bit times
  localparam int CLK_PERIOD_PS = 10000;
  localparam int SLOT_BITS = 512;
  localparam int IPG_BITS = 96;
  localparam int BIT_PS_10 = 100000;
  localparam int BIT_PS_100 = 10000;
  localparam int BIT_PS_1000 = 1000;
  localparam int SLOT_CYC_100 = SLOT_BITS * BIT_PS_100 / CLK_PERIOD_PS;
  localparam int SLOT_CYC_1000 = SLOT_BITS * BIT_PS_1000 / CLK_PERIOD_PS;
  localparam int IPG_CYC_10 =
    (IPG_BITS * BIT_PS_10 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IPG_CYC_100 =
    (IPG_BITS * BIT_PS_100 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IPG_CYC_1000 =
    (IPG_BITS * BIT_PS_1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PACE_GAPS = 4;
  localparam int SLOT_W = 13;
  localparam int GAP_W = 12;

  typedef enum logic [0:0] {GATE_OPEN, GATE_GAP} mpa_gate_e;

endpackage

// ===== verification/mac_pacing_pause_addr_tb.sv
// bench for the pacing, pause timer and station address block
// assumes the engine model beside it and a short 10 Mb/s slot
`timescale 1ns/1ps
module mac_pacing_pause_addr_tb
  import mpa_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic we = 1'b0, tx_done, coll, psent, prcvd, dav, ok, preq, pace;
  logic mt, mtv, ack;
  logic hold = 1'b0;
  logic [1:0] spd = SPD_1000;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [15:0] ptx, prx;
  logic [31:0] wdat = 32'h0, rdat, q1, q2;
  logic [47:0] da;
  int miscompares = 0, check_count = 0, cycles = 0, n;

  always #5 clk = ~clk;

  mpa_core #(.SLOT_CYC_10(1)) mpa_core_inst (.REF_CLK(clk), .RST(rst),
    .CE(ce), .LINK_SPEED(spd), .TX_DONE(tx_done), .TX_COLL_DEFER(coll),
    .TX_PAUSE_SENT(psent), .TX_PAUSE_TIME(ptx), .RX_FLOW_HOLD(hold),
    .RX_PAUSE_RCVD(prcvd), .RX_PAUSE_TIME(prx), .RX_DA_VALID(dav),
    .RX_DA(da), .TX_START_OK(ok), .TX_PAUSE_REQ(preq),
    .PACING_ACTIVE(pace), .ADDR_MATCH(mt), .ADDR_MATCH_VALID(mtv),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
    .DAT_I(wdat), .ACK_O(ack), .DAT_O(rdat));
  mpa_engine_model mpa_engine_model_inst (.clk(clk), .start_ok(ok),
    .tx_done(tx_done), .coll_defer(coll), .pause_sent(psent),
    .pause_out(ptx), .pause_rcvd(prcvd), .pause_in(prx),
    .da_valid(dav), .da(da));

  // ==========
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic gap(input logic c);
    mpa_engine_model_inst.frame(c);
    n = 0;
    @(negedge clk);
    while (ok !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic mchk(input logic [47:0] a, input logic e);
    mpa_engine_model_inst.addr(a);
    @(negedge clk);
    chk({31'h0, mtv}, 32'h1);
    chk({31'h0, mt}, {31'h0, e});
  endtask

  // ==========
  // scenarios
  task automatic t_reset();
    for (int a = 0; a < 28; a += 4) rd(8'(a), 32'h0);
    wr(8'h18, 32'hffffffff);
    rd(8'h18, 32'h0);
    wr(OFS_PACE, 32'hffffffff);
    rd(OFS_PACE, 32'h0);
    wr(OFS_INDEX, 32'hffffffff);
    rd(OFS_INDEX, 32'h7);
  endtask
  task automatic t_pacing();
    gap(1'b0);
    chk(32'(n > 4 && n < 16), 32'h1);
    rd(OFS_PACE, 32'h0);
    gap(1'b1);
    chk(32'(n > 4 && n < 16), 32'h1);
    rd(OFS_PACE, 32'h1f);
    chk({31'h0, pace}, 32'h1);
    gap(1'b0);
    chk(32'(n > 34 && n < 46), 32'h1);
    rd(OFS_PACE, 32'h1e);
    gap(1'b1);
    chk(32'(n > 4 && n < 16), 32'h1);
  endtask
  task automatic t_pause();
    // tx timer at 1G: three slots of 51 cycles
    mpa_engine_model_inst.pause(1'b1, 16'h0003);
    wb(1'b0, OFS_TX_PAUSE_TIMER_VIEW, 32'h0, q1);
    chk(32'(q1 > 1 && q1 < 4), 32'h1);
    n = 0;
    while (ok !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n > 95 && n < 160), 32'h1);
    rd(OFS_TX_PAUSE_TIMER_VIEW, 32'h0);
    // rx timer at 100M: 512-cycle slots
    spd <= SPD_100;
    mpa_engine_model_inst.pause(1'b0, PAUSE_MAX);
    wb(1'b0, OFS_RX_PAUSE_TIMER_VIEW, 32'h0, q1);
    chk(32'(q1 > 32'hfefd && q1 <= 32'hff00), 32'h1);
    repeat (1536) @(posedge clk);
    wb(1'b0, OFS_RX_PAUSE_TIMER_VIEW, 32'h0, q2);
    chk(32'(q1 - q2 > 2 && q1 - q2 < 5), 32'h1);
    // one-cycle slot at 10M runs the rx timer out
    spd <= SPD_10;
    hold <= 1'b1;
    n = 0;
    while (preq !== 1'b1 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n > 60000 && n < 70000), 32'h1);
    @(negedge clk);
    chk({31'h0, preq}, 32'h0);
    wb(1'b0, OFS_RX_PAUSE_TIMER_VIEW, 32'h0, q1);
    chk(32'(q1 > 32'hfef0 && q1 <= 32'hff00), 32'h1);
    // enable low freezes the timer
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    wb(1'b0, OFS_RX_PAUSE_TIMER_VIEW, 32'h0, q2);
    chk(32'(q1 - q2 < 10), 32'h1);
  endtask
  task automatic t_addr();
    wr(OFS_INDEX, 32'h2);
    wr(OFS_ADDR_HI, 32'haabbccdd);
    wr(OFS_ADDR_LO, 32'hffff1234);
    rd(OFS_ADDR_HI, 32'haabbccdc);
    rd(OFS_ADDR_LO, 32'h00001234);
    mchk(48'hdccc_bbaa_3412, 1'b1);
    wr(OFS_INDEX, 32'h3);
    rd(OFS_ADDR_LO, 32'h00000034);
    mchk(48'hdccc_bbaa_3456, 1'b0);
    wr(OFS_ADDR_LO, 32'h00005634);
    mchk(48'hdccc_bbaa_3456, 1'b1);
    mchk(48'hdccc_bbaa_3412, 1'b1);
    mchk(48'hddcc_bbaa_3412, 1'b0);
  endtask

  // ==========
  // run control
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pacing();
    t_pause();
    t_addr();
    give_verdict();
  end
endmodule // mac_pacing_pause_addr_tb

// ===== verification/mpa_engine_model.sv
// frame engine model: frame, pause and address events as pulses
// assumes REF_CLK and the block's start permission
`timescale 1ns/1ps
module mpa_engine_model (
  // clock and permission
  input wire logic clk,
  input wire logic start_ok,
  // transmit events
  output logic tx_done = 1'b0,
  output logic coll_defer = 1'b0,
  output logic pause_sent = 1'b0,
  output logic [15:0] pause_out = 16'h0000,
  // receive events
  output logic pause_rcvd = 1'b0,
  output logic [15:0] pause_in = 16'h0000,
  output logic da_valid = 1'b0,
  output logic [47:0] da = 48'h0
);
  // ==========
  // event tasks
  task automatic frame(input logic c);
    @(posedge clk);
    while (start_ok !== 1'b1) begin
      @(posedge clk);
    end
    tx_done <= 1'b1;
    coll_defer <= c;
    @(posedge clk);
    tx_done <= 1'b0;
    coll_defer <= ~c;
  endtask
  task automatic pause(input logic rcvd, input logic [15:0] t);
    @(posedge clk);
    pause_rcvd <= rcvd;
    pause_sent <= ~rcvd;
    pause_in <= t;
    pause_out <= t;
    @(posedge clk);
    pause_rcvd <= 1'b0;
    pause_sent <= 1'b0;
    pause_in <= ~t;
    pause_out <= ~t;
  endtask
  task automatic addr(input logic [47:0] a);
    @(posedge clk);
    da_valid <= 1'b1;
    da <= a;
    @(posedge clk);
    da_valid <= 1'b0;
    da <= ~a;
  endtask
endmodule // mpa_engine_model

// ===== verification/mpa_props.sv
// checker of the pacing, pause and address outputs
// assumes binding onto mpa_core and a single clock domain
`timescale 1ns/1ps
module mpa_props (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // causes
  input wire logic CE,
  input wire logic TX_DONE,
  input wire logic TX_COLL_DEFER,
  input wire logic RX_PAUSE_RCVD,
  input wire logic [15:0] RX_PAUSE_TIME,
  input wire logic RX_DA_VALID,
  input wire logic CYC_I,
  input wire logic STB_I,
  // effects
  input wire logic TX_START_OK,
  input wire logic TX_PAUSE_REQ,
  input wire logic PACING_ACTIVE,
  input wire logic ADDR_MATCH_VALID,
  input wire logic ACK_O
);
  // ==========
  // properties
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  AST_ACK: assert property (CYC_I && STB_I && CE && !ACK_O |=> ACK_O)
    else $error("request not acked");
  AST_ACK_ONE: assert property (ACK_O && CE |=> !ACK_O)
    else $error("ack longer than one cycle");
  AST_COLL: assert property (CE && TX_DONE && TX_COLL_DEFER |->
    ##[1:2] PACING_ACTIVE) else $error("pacing not started");
  AST_RISE: assert property ($rose(PACING_ACTIVE) |->
    $past(TX_DONE && TX_COLL_DEFER) || $past(TX_DONE && TX_COLL_DEFER, 2))
    else $error("pacing started without collision");
  AST_DONE: assert property (CE && TX_DONE |-> ##[1:2] !TX_START_OK)
    else $error("start not withheld after frame");
  AST_PAUSE: assert property (CE && RX_PAUSE_RCVD &&
    RX_PAUSE_TIME != 16'h0000 |-> ##[1:2] !TX_START_OK)
    else $error("start not blocked by pause");
  AST_REQ: assert property (TX_PAUSE_REQ && CE |=> !TX_PAUSE_REQ)
    else $error("pause request too long");
  AST_MATCH: assert property (CE && RX_DA_VALID |=> ADDR_MATCH_VALID)
    else $error("no match result");
  COV_COLL: cover property (TX_DONE && TX_COLL_DEFER);
  COV_PAUSE: cover property (RX_PAUSE_RCVD);
  COV_MATCH: cover property (ADDR_MATCH_VALID);
  COV_REQ: cover property (TX_PAUSE_REQ);
endmodule // mpa_props

bind mpa_core mpa_props mpa_props_inst (.REF_CLK, .RST, .CE, .TX_DONE,
  .TX_COLL_DEFER, .RX_PAUSE_RCVD, .RX_PAUSE_TIME, .RX_DA_VALID, .CYC_I,
  .STB_I, .TX_START_OK, .TX_PAUSE_REQ, .PACING_ACTIVE, .ADDR_MATCH_VALID,
  .ACK_O);
